//--- iec_style_delay_timers.sv
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module iec_style_delay_timers (
   // clock, reset, enable
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          ce,
   // apb slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [timer_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   // timer results
   output logic                               timer_out,
   output logic      [timer_pkg::TIME_W-1:0]  elapsed_out
);

   timer_if tif ();

   logic                               trig;
   logic [timer_pkg::CTRL_MODE_W-1:0]  mode_field;
   timer_pkg::time_t                   preset_time;
   timer_pkg::time_t                   elapsed_time;
   logic [31:0]                        elapsed_hi_snap;
   logic                               q;
   logic                               timing;
   logic                               ack;
   logic                               access;
   logic                               first_acc;
   logic                               wr_en;
   logic                               mapped;
   logic                               mode_wr;
   logic [31:0]                        rd_mux;
   timer_pkg::time_t                   next_et;
   logic                               next_q;
   logic                               next_timing;

   // helpers
   us_tick_gen u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .tb      (tif.tick_src)
   );

   trig_edge_det u_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .ed      (tif.edge_src)
   );

   assign tif.trig_level = trig;

   // apb access phase, one wait state
   assign access = psel && penable;
   assign pready = ack;
   assign wr_en  = access && ack && pwrite && ce;
   assign first_acc = access && !ack; // first access cycle samples read data

   // address decode
   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         timer_pkg::CTRL_OFF: begin
            rd_mux[timer_pkg::CTRL_TRIG_BIT] = trig;
            rd_mux[timer_pkg::CTRL_MODE_LSB +: timer_pkg::CTRL_MODE_W] = mode_field;
         end
         timer_pkg::PRESET_LO_OFF:  rd_mux = preset_time[31:0];
         timer_pkg::PRESET_HI_OFF:  rd_mux = preset_time[63:32];
         timer_pkg::ELAPSED_LO_OFF: rd_mux = elapsed_time[31:0];
         timer_pkg::ELAPSED_HI_OFF: rd_mux = elapsed_hi_snap;
         timer_pkg::STATUS_OFF: begin
            rd_mux[timer_pkg::STAT_Q_BIT]   = q;
            rd_mux[timer_pkg::STAT_RUN_BIT] = timing;
         end
         default: mapped = 1'b0;
      endcase
   end

   // wait-state flag and read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack     <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (ce) begin
         ack <= first_acc;
         if (first_acc) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= !mapped;
         end
      end
   end

   // high half of elapsed frozen when the low half is read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         elapsed_hi_snap <= 32'h0000_0000;
      end else if (ce && first_acc && !pwrite && paddr == timer_pkg::ELAPSED_LO_OFF) begin
         elapsed_hi_snap <= elapsed_time[63:32];
      end
   end

   // control and preset registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig        <= 1'b0;
         mode_field  <= timer_pkg::CTRL_MODE_RST;
         preset_time <= timer_pkg::TIME_ZERO;
      end else if (wr_en) begin
         unique case (paddr)
            timer_pkg::CTRL_OFF: begin
               trig       <= pwdata[timer_pkg::CTRL_TRIG_BIT];
               mode_field <= pwdata[timer_pkg::CTRL_MODE_LSB +: timer_pkg::CTRL_MODE_W];
            end
            timer_pkg::PRESET_LO_OFF: preset_time[31:0]  <= pwdata;
            timer_pkg::PRESET_HI_OFF: preset_time[63:32] <= pwdata;
            default: ;
         endcase
      end
   end

   // a change of behaviour restarts the timer from idle
   assign mode_wr = wr_en && paddr == timer_pkg::CTRL_OFF
                    && pwdata[timer_pkg::CTRL_MODE_LSB +: timer_pkg::CTRL_MODE_W] != mode_field;

   // per-behaviour next state
   always_comb begin
      next_et     = elapsed_time;
      next_q      = 1'b0;
      next_timing = 1'b0;
      unique case (timer_pkg::mode_e'(mode_field))
         timer_pkg::on_delay_mode: begin
            if (!trig) begin
               next_et = timer_pkg::TIME_ZERO;
            end else begin
               next_et = timer_pkg::sat_inc(elapsed_time, preset_time, tif.tick);
            end
            next_q      = trig && next_et >= preset_time;
            next_timing = trig && next_et < preset_time;
         end
         timer_pkg::off_delay_mode: begin
            if (trig) begin
               next_et = timer_pkg::TIME_ZERO;
            end else if (timing || tif.fall) begin
               next_et = timer_pkg::sat_inc(elapsed_time, preset_time, tif.tick && timing);
            end
            next_timing = !trig && (timing || tif.fall) && next_et < preset_time;
            next_q      = trig || next_timing;
         end
         timer_pkg::pulse_mode: begin
            if (timing) begin
               next_et = timer_pkg::sat_inc(elapsed_time, preset_time, tif.tick);
            end else if (!trig) begin
               next_et = timer_pkg::TIME_ZERO;
            end
            next_timing = (timing || tif.rise) && next_et < preset_time;
            next_q      = next_timing;
         end
         default: begin
            next_et = timer_pkg::TIME_ZERO;
         end
      endcase
   end

   // timer state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         elapsed_time <= timer_pkg::TIME_ZERO;
         q            <= 1'b0;
         timing       <= 1'b0;
      end else if (ce) begin
         if (mode_wr) begin
            elapsed_time <= timer_pkg::TIME_ZERO;
            q            <= 1'b0;
            timing       <= 1'b0;
         end else begin
            elapsed_time <= next_et;
            q            <= next_q;
            timing       <= next_timing;
         end
      end
   end

   assign timer_out   = q;
   assign elapsed_out = elapsed_time;

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_on_adv;
      ce && !mode_wr && mode_field == timer_pkg::on_delay_mode && trig && tif.tick
         && elapsed_time < preset_time |=> elapsed_time == $past(elapsed_time) + 1;
   endproperty
   a_on_adv: assert property (p_on_adv) else $error("on-delay count did not advance");

   property p_on_q;
      ce && !mode_wr && mode_field == timer_pkg::on_delay_mode && trig
         |=> q == (elapsed_time >= $past(preset_time));
   endproperty
   a_on_q: assert property (p_on_q) else $error("on-delay output wrong");

   property p_on_clear;
      ce && mode_field == timer_pkg::on_delay_mode && !trig |=> elapsed_time == 0 && !q;
   endproperty
   a_on_clear: assert property (p_on_clear) else $error("on-delay not cleared");

   property p_off_high;
      ce && !mode_wr && mode_field == timer_pkg::off_delay_mode && trig
         |=> q && elapsed_time == 0;
   endproperty
   a_off_high: assert property (p_off_high) else $error("off-delay not high");

   property p_off_stop;
      ce && !mode_wr && mode_field == timer_pkg::off_delay_mode && !trig
         && elapsed_time >= preset_time |=> !q && $stable(elapsed_time);
   endproperty
   a_off_stop: assert property (p_off_stop) else $error("off-delay did not stop");

   property p_off_start;
      ce && !mode_wr && mode_field == timer_pkg::off_delay_mode && tif.fall
         && preset_time != 0 |=> q && timing;
   endproperty
   a_off_start: assert property (p_off_start) else $error("off-delay dropped early");

   property p_pulse_start;
      ce && !mode_wr && mode_field == timer_pkg::pulse_mode && tif.rise
         && !timing && preset_time > elapsed_time |=> q;
   endproperty
   a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");

   property p_pulse_end;
      ce && !mode_wr && mode_field == timer_pkg::pulse_mode && trig && !tif.rise
         && elapsed_time >= preset_time |=> !q && $stable(elapsed_time);
   endproperty
   a_pulse_end: assert property (p_pulse_end) else $error("pulse did not end");

   property p_pulse_clr;
      ce && mode_field == timer_pkg::pulse_mode && !trig && !timing |=> elapsed_time == 0;
   endproperty
   a_pulse_clr: assert property (p_pulse_clr) else $error("pulse elapsed not cleared");

   property p_no_wrap;
      ce |=> elapsed_time == 0 || elapsed_time == $past(elapsed_time)
         || elapsed_time == $past(elapsed_time) + 1;
   endproperty
   a_no_wrap: assert property (p_no_wrap) else $error("elapsed jumped");

   property p_freeze;
      !ce |=> $stable(elapsed_time) && $stable(q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved without enable");

   // on-delay reaching, holding and aborting
   property p_on_reach;
      ce && !mode_wr && mode_field == timer_pkg::on_delay_mode && trig && tif.tick
         && elapsed_time + timer_pkg::TIME_ONE == preset_time
         |=> q && elapsed_time == $past(preset_time);
   endproperty
   a_on_reach: assert property (p_on_reach) else $error("on-delay missed the preset");

   property p_on_hold;
      ce && !mode_wr && mode_field == timer_pkg::on_delay_mode && trig
         && elapsed_time >= preset_time |=> q && $stable(elapsed_time);
   endproperty
   a_on_hold: assert property (p_on_hold) else $error("on-delay did not hold");

   property p_on_abort;
      ce && mode_field == timer_pkg::on_delay_mode && tif.fall && elapsed_time < preset_time
         |=> elapsed_time == timer_pkg::TIME_ZERO && !q;
   endproperty
   a_on_abort: assert property (p_on_abort) else $error("on-delay abort not cleared");

   // off-delay counting, ending, holding and retriggering
   property p_off_count;
      ce && !mode_wr && mode_field == timer_pkg::off_delay_mode && !trig && timing
         && tif.tick && elapsed_time < preset_time
         |=> elapsed_time == $past(elapsed_time) + timer_pkg::TIME_ONE;
   endproperty
   a_off_count: assert property (p_off_count) else $error("off-delay did not count");

   property p_off_keep;
      ce && !mode_wr && mode_field == timer_pkg::off_delay_mode && !trig && timing
         |=> q == (elapsed_time < $past(preset_time));
   endproperty
   a_off_keep: assert property (p_off_keep) else $error("off-delay output wrong");

   property p_off_reach;
      ce && !mode_wr && mode_field == timer_pkg::off_delay_mode && !trig && timing
         && tif.tick && elapsed_time + timer_pkg::TIME_ONE == preset_time
         |=> !q && !timing;
   endproperty
   a_off_reach: assert property (p_off_reach) else $error("off-delay did not end");

   property p_off_hold;
      ce && !mode_wr && mode_field == timer_pkg::off_delay_mode && !trig && !timing
         && !tif.fall |=> !q && $stable(elapsed_time);
   endproperty
   a_off_hold: assert property (p_off_hold) else $error("off-delay elapsed moved");

   property p_off_rise;
      ce && !mode_wr && mode_field == timer_pkg::off_delay_mode && tif.rise
         |=> q && !timing && elapsed_time == timer_pkg::TIME_ZERO;
   endproperty
   a_off_rise: assert property (p_off_rise) else $error("off-delay rise wrong");

   property p_off_retrig;
      ce && !mode_wr && mode_field == timer_pkg::off_delay_mode && tif.rise && timing
         |=> q && elapsed_time == timer_pkg::TIME_ZERO;
   endproperty
   a_off_retrig: assert property (p_off_retrig) else $error("off-delay retrigger wrong");

   // pulse advancing, ending and clearing
   property p_pulse_adv;
      ce && !mode_wr && mode_field == timer_pkg::pulse_mode && timing && tif.tick
         && elapsed_time < preset_time
         |=> elapsed_time == $past(elapsed_time) + timer_pkg::TIME_ONE;
   endproperty
   a_pulse_adv: assert property (p_pulse_adv) else $error("pulse did not advance");

   property p_pulse_stop;
      ce && !mode_wr && mode_field == timer_pkg::pulse_mode && timing && tif.tick
         && elapsed_time + timer_pkg::TIME_ONE == preset_time
         |=> !q && !timing && elapsed_time == $past(preset_time);
   endproperty
   a_pulse_stop: assert property (p_pulse_stop) else $error("pulse did not stop");

   property p_pulse_fall;
      ce && !mode_wr && mode_field == timer_pkg::pulse_mode && tif.fall && !timing
         |=> elapsed_time == timer_pkg::TIME_ZERO;
   endproperty
   a_pulse_fall: assert property (p_pulse_fall) else $error("pulse fall not cleared");

   // apb handshake
   property p_ready_setup;
      ce && psel && !penable |=> !pready;
   endproperty
   a_ready_setup: assert property (p_ready_setup) else $error("ready in setup phase");

   property p_ready_pulse;
      ce && pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

   property p_ready_err;
      ce && psel && penable && !pready |=> pready && pslverr != $past(mapped);
   endproperty
   a_ready_err: assert property (p_ready_err) else $error("wait state or error wrong");

endmodule

//--- timer_pkg.sv
// Summary of operation
// - on-delay: while trigger is high, elapsed time advances from zero each tick
// - on-delay: output asserts when elapsed equals preset; elapsed then holds at preset
// - on-delay: trigger falling after preset reached clears elapsed and output
// - on-delay: trigger falling before preset clears elapsed; output stays low
// - off-delay: output is high for as long as trigger is high
// - off-delay: falling trigger starts counting; output stays high below preset
// - off-delay: elapsed equal to preset drops output and stops counting
// - off-delay: elapsed holds at preset; rising trigger resets it to zero
// - off-delay: rising trigger clears elapsed and raises output again
// - off-delay: trigger rising before preset clears elapsed; output stays high
// - pulse: rising trigger raises output and starts elapsed time advancing
// - pulse: elapsed equal to preset drops output and stops advancing
// - pulse: trigger low with no pulse running clears elapsed time to zero
package timer_pkg;

   // time values
   localparam int TIME_W        = 64;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TIME_BASE_NS  = 1000;
   localparam int TICK_CYCLES   = (TIME_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICK_CNT_W    = $clog2(TICK_CYCLES);
   localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES - 1);
   localparam logic [TICK_CNT_W-1:0] TICK_ZERO = '0;

   // register byte offsets
   localparam logic [7:0] CTRL_OFF       = 8'h00;
   localparam logic [7:0] PRESET_LO_OFF  = 8'h04;
   localparam logic [7:0] PRESET_HI_OFF  = 8'h08;
   localparam logic [7:0] ELAPSED_LO_OFF = 8'h0C;
   localparam logic [7:0] ELAPSED_HI_OFF = 8'h10;
   localparam logic [7:0] STATUS_OFF     = 8'h14;
   localparam int         ADDR_W         = 8;

   // control fields
   localparam int         CTRL_TRIG_BIT = 0;
   localparam int         CTRL_MODE_LSB = 1;
   localparam int         CTRL_MODE_W   = 2;
   localparam logic [1:0] CTRL_MODE_RST = 2'h0;

   // status fields
   localparam int STAT_Q_BIT   = 0;
   localparam int STAT_RUN_BIT = 1;

   // timer behaviours, encoded in the control mode field
   typedef enum logic [CTRL_MODE_W-1:0] {
      on_delay_mode,
      off_delay_mode,
      pulse_mode
   } mode_e;

   typedef logic [TIME_W-1:0] time_t;
   localparam time_t TIME_ZERO = '0;
   localparam time_t TIME_ONE  = time_t'(1);

   // advance toward the preset, never past it and never wrapping
   function automatic time_t sat_inc(input time_t et, input time_t pt, input logic tick);
      sat_inc = (tick && et < pt) ? et + TIME_ONE : et;
   endfunction

endpackage

//--- timer_if.sv
`timescale 1ns/1ps
// time-base tick and trigger edges shared between core and helpers
interface timer_if;
   logic tick;
   logic trig_level;
   logic rise;
   logic fall;

   modport tick_src (output tick);
   modport edge_src (input trig_level, output rise, output fall);
   modport core     (input tick, input rise, input fall, output trig_level);
endinterface

//--- us_tick_gen.sv
`timescale 1ns/1ps
module us_tick_gen (
   // clock, reset, enable
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   // tick out
   timer_if.tick_src tb
);

   logic [timer_pkg::TICK_CNT_W-1:0] div_cnt;

   // one tick per microsecond
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= timer_pkg::TICK_ZERO;
      end else if (ce) begin
         div_cnt <= (div_cnt == timer_pkg::TICK_LAST) ? timer_pkg::TICK_ZERO
                                                      : div_cnt + 1'b1;
      end
   end

   assign tb.tick = ce && (div_cnt == timer_pkg::TICK_LAST);

endmodule

//--- trig_edge_det.sv
`timescale 1ns/1ps
module trig_edge_det (
   // clock, reset, enable
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   // trigger in, edges out
   timer_if.edge_src ed
);

   logic trig_prev;

   // previous-cycle copy of the trigger level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_prev <= 1'b0;
      end else if (ce) begin
         trig_prev <= ed.trig_level;
      end
   end

   // edges against the previous level
   assign ed.rise = ed.trig_level && !trig_prev;
   assign ed.fall = !ed.trig_level && trig_prev;

endmodule

//--- ctl_prog_model.sv
`timescale 1ns/1ps
// controlling program: supplies preset and trigger, reads results over apb
module ctl_prog_model (
   // clock
   input  wire logic                         pclk,
   // apb master side
   output logic                              psel,
   output logic                              penable,
   output logic                              pwrite,
   output logic      [timer_pkg::ADDR_W-1:0] paddr,
   output logic      [31:0]                  pwdata,
   input  wire logic [31:0]                  prdata,
   input  wire logic                         pready,
   input  wire logic                         pslverr
);
   // bus idle from time zero
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = '0;
      pwdata  = 32'h0;
   end

   // one transfer, request held until pready is sampled high
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~wd; // stale data does not linger
   endtask

   // time-typed preset as two words
   task automatic set_preset(input logic [63:0] pt);
      logic [31:0] rd;
      logic        err;
      xfer(1'b1, timer_pkg::PRESET_LO_OFF, pt[31:0], rd, err);
      xfer(1'b1, timer_pkg::PRESET_HI_OFF, pt[63:32], rd, err);
   endtask

   // boolean trigger level with behaviour select
   task automatic set_ctrl(input timer_pkg::mode_e m, input logic trig);
      logic [31:0] rd;
      logic        err;
      xfer(1'b1, timer_pkg::CTRL_OFF, {29'h0, m, trig}, rd, err);
   endtask
endmodule

//--- iec_style_delay_timers_bench.sv
`timescale 1ns/1ps
module iec_style_delay_timers_bench;
   logic        pclk;
   logic        presetn;
   logic        ce;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        timer_out;
   logic [63:0] elapsed_out;
   logic [31:0] rd;
   logic        err;
   int          miscompares;
   int          compares;

   ctl_prog_model ctl_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   iec_style_delay_timers dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_out(timer_out), .elapsed_out(elapsed_out));

   // 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // compare one result
   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge pclk);
   endtask

   // bounded wait for the output level
   task automatic wait_out(input logic lvl, input int limit);
      int i;
      i = 0;
      while (timer_out !== lvl && i < limit) begin
         @(negedge pclk);
         i++;
      end
   endtask

   // reset state, refused and read-only accesses
   task automatic t_reset();
      chk("out_rst", 64'h0, timer_out);
      chk("et_rst", 64'h0, elapsed_out);
      ctl_u.xfer(1'b0, timer_pkg::STATUS_OFF, 32'h0, rd, err);
      chk("status_rst", 64'h0, rd);
      ctl_u.xfer(1'b1, timer_pkg::ELAPSED_LO_OFF, 32'h55, rd, err);
      ctl_u.xfer(1'b0, timer_pkg::ELAPSED_LO_OFF, 32'h0, rd, err);
      chk("et_ro", 64'h0, rd);
      ctl_u.xfer(1'b0, 8'h20, 32'h0, rd, err);
      chk("unmapped_err", 64'h1, err);
      chk("unmapped_rd", 64'h0, rd);
   endtask

   // on-delay full run, hold, clear on falling trigger
   task automatic t_on_delay();
      ctl_u.set_preset(64'h5);
      ctl_u.set_ctrl(timer_pkg::on_delay_mode, 1'b1);
      settle(250);
      chk("on_count", 64'h1, elapsed_out >= 64'h2 && elapsed_out <= 64'h3);
      chk("on_early", 64'h0, timer_out);
      wait_out(1'b1, 400);
      chk("on_out", 64'h1, timer_out);
      chk("on_et", 64'h5, elapsed_out);
      settle(300);
      chk("on_hold", 64'h5, elapsed_out);
      ctl_u.xfer(1'b0, timer_pkg::ELAPSED_LO_OFF, 32'h0, rd, err);
      chk("et_lo", 64'h5, rd);
      ctl_u.xfer(1'b0, timer_pkg::ELAPSED_HI_OFF, 32'h0, rd, err);
      chk("et_hi", 64'h0, rd);
      ctl_u.set_ctrl(timer_pkg::on_delay_mode, 1'b0);
      settle(3);
      chk("on_clr_out", 64'h0, timer_out);
      chk("on_clr_et", 64'h0, elapsed_out);
   endtask

   // on-delay trigger dropped before the preset
   task automatic t_on_abort();
      ctl_u.set_ctrl(timer_pkg::on_delay_mode, 1'b1);
      settle(150);
      chk("ab_out", 64'h0, timer_out);
      ctl_u.set_ctrl(timer_pkg::on_delay_mode, 1'b0);
      settle(3);
      chk("ab_et", 64'h0, elapsed_out);
      settle(500);
      chk("ab_out_late", 64'h0, timer_out);
   endtask

   // off-delay run, hold, retrigger after and before the preset
   task automatic t_off_delay();
      ctl_u.set_ctrl(timer_pkg::off_delay_mode, 1'b1);
      settle(200);
      chk("off_high", 64'h1, timer_out);
      ctl_u.set_ctrl(timer_pkg::off_delay_mode, 1'b0);
      settle(250);
      chk("off_keep", 64'h1, timer_out);
      chk("off_count", 64'h1, elapsed_out >= 64'h2 && elapsed_out <= 64'h3);
      ctl_u.xfer(1'b0, timer_pkg::STATUS_OFF, 32'h0, rd, err);
      chk("off_status", 64'h3, rd);
      wait_out(1'b0, 400);
      chk("off_drop", 64'h0, timer_out);
      chk("off_et", 64'h5, elapsed_out);
      settle(300);
      chk("off_hold", 64'h5, elapsed_out);
      ctl_u.set_ctrl(timer_pkg::off_delay_mode, 1'b1);
      settle(3);
      chk("off_rise_et", 64'h0, elapsed_out);
      chk("off_rise_out", 64'h1, timer_out);
      ctl_u.set_ctrl(timer_pkg::off_delay_mode, 1'b0);
      settle(150);
      ctl_u.set_ctrl(timer_pkg::off_delay_mode, 1'b1);
      settle(3);
      chk("off_re_out", 64'h1, timer_out);
      chk("off_re_et", 64'h0, elapsed_out);
   endtask

   // pulse run, hold at preset, clear on falling trigger
   task automatic t_pulse();
      ctl_u.set_ctrl(timer_pkg::pulse_mode, 1'b0);
      settle(3);
      ctl_u.set_ctrl(timer_pkg::pulse_mode, 1'b1);
      settle(3);
      chk("p_out", 64'h1, timer_out);
      settle(200);
      chk("p_count", 64'h1, elapsed_out >= 64'h1 && elapsed_out <= 64'h3);
      wait_out(1'b0, 400);
      chk("p_et", 64'h5, elapsed_out);
      settle(200);
      chk("p_hold", 64'h5, elapsed_out);
      ctl_u.set_ctrl(timer_pkg::pulse_mode, 1'b0);
      settle(3);
      chk("p_clr", 64'h0, elapsed_out);
      // unused mode code keeps the timer idle even with the trigger high
      ctl_u.xfer(1'b1, timer_pkg::CTRL_OFF, 32'h0000_0007, rd, err);
      ctl_u.xfer(1'b0, timer_pkg::CTRL_OFF, 32'h0, rd, err);
      chk("ctrl_rd", 64'h7, rd);
      settle(200);
      chk("idle_out", 64'h0, timer_out);
      chk("idle_et", 64'h0, elapsed_out);
   endtask

   // counts and verdict
   task automatic close_out();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // hang guard
   initial begin
      #200us;
      miscompares++;
      close_out();
   end

   // main sequence
   initial begin
      miscompares = 0;
      compares = 0;
      presetn = 1'b0;
      ce = 1'b1;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      settle(1);
      t_reset();
      t_on_delay();
      t_on_abort();
      t_off_delay();
      t_pulse();
      close_out();
   end
endmodule
